// ### accel_sample_readout_defs.svh
// Register map, field positions and reset values of the sample read-out block
`ifndef ACCEL_SAMPLE_READOUT_DEFS_SVH
`define ACCEL_SAMPLE_READOUT_DEFS_SVH

`define REG_SAMPLE_FLAGS   8'h00
`define REG_X_HIGH         8'h01
`define REG_X_LOW          8'h02
`define REG_Y_HIGH         8'h03
`define REG_Y_LOW          8'h04
`define REG_Z_HIGH         8'h05
`define REG_Z_LOW          8'h06
`define REG_MODE_VIEW      8'h0B
`define REG_LAST_FULL      8'h06
`define REG_LAST_FAST      8'h05

`define FLAGS_RESET        8'h00
`define MODE_RESET         2'h0
`define SAMPLE_RESET       12'h000
`define BIT_ALL_OVERRUN    7
`define BIT_ALL_NEW        3
`define SAMPLE_BITS        12
`define BYTE_BITS          4'h8

`endif

// ### accel_sample_readout_pkg.sv
// Types shared by the sample read-out block
package accel_sample_readout_pkg;

  typedef enum logic [7:0] {
    IDLE     = 8'h01,
    ADDR     = 8'h02,
    ADDR_ACK = 8'h04,
    PTR      = 8'h08,
    PTR_ACK  = 8'h10,
    SEND     = 8'h20,
    HOST_ACK = 8'h40,
    WAIT     = 8'h80
  } bus_state_type;

  typedef logic [11:0] sample_type;

endpackage : accel_sample_readout_pkg

// ### accel_sample_readout_regs.sv
// Three-axis sample read-out registers behind an I2C slave port
`timescale 1ns/100ps
`default_nettype none
`include "accel_sample_readout_defs.svh"
module accel_sample_readout_regs
  import accel_sample_readout_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR  = 7'h1C, // Arbitrary bus address
  parameter int         BUF_DEPTH = 2
) (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       scl,
  input  wire logic       sdaIn,
  output logic            sdaOut,
  output logic            sdaOe,
  input  wire logic       sampleValid,
  output logic            sampleReady,
  input  wire sample_type sampleX,
  input  wire sample_type sampleY,
  input  wire sample_type sampleZ,
  input  wire logic       fastRead,
  input  wire logic [1:0] operatingMode,
  input  wire logic       sleepWakeEvent,
  output logic            sleepWakeEventFlag
);

  localparam int PW = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;

  function automatic logic [PW-1:0] bump(input logic [PW-1:0] idx);
    bump = (idx == PW'(BUF_DEPTH - 1)) ? '0 : idx + PW'(1);
  endfunction : bump

  function automatic logic [7:0] nextPtr(input logic [7:0] p, input logic fast);
    if (fast && p == `REG_LAST_FAST)
      nextPtr = `REG_SAMPLE_FLAGS;
    else if (!fast && p == `REG_LAST_FULL)
      nextPtr = `REG_SAMPLE_FLAGS;
    else if (fast && p[0] && p < `REG_LAST_FAST)
      nextPtr = p + 8'h02;
    else
      nextPtr = p + 8'h01;
  endfunction : nextPtr

  function automatic logic [7:0] highByte(input sample_type s);
    highByte = s[11:4];
  endfunction : highByte

  function automatic logic [7:0] lowByte(input sample_type s, input logic ok);
    lowByte = ok ? {s[3:0], 4'h0} : 8'h00;
  endfunction : lowByte

  // Pin synchronisers; stage 0 feeds only stage 1
  logic [2:0]      sclSync_q;
  logic [2:0]      sdaSync_q;
  bus_state_type   state_q;
  logic [3:0]      bitCnt_q;
  logic [7:0]      shift_q;
  logic            rw_q;
  logic            firstPtr_q;
  logic            ackd_q;
  logic [7:0]      ptr_q;
  logic            pairLock_q;
  logic [1:0]      mode_q;
  sample_type      axis_q [3];
  logic [35:0]     buf_q [BUF_DEPTH];
  logic [PW-1:0]   wrIdx_q;
  logic [PW-1:0]   rdIdx_q;
  logic [PW:0]     count_q;
  logic [2:0]      newAxis_q;
  logic [2:0]      overAxis_q;
  logic            allNew_q;
  logic            allOver_q;
  logic [2:0]      seenHigh_q;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sclSync_q <= 3'h7;
      sdaSync_q <= 3'h7;
    end else begin
      sclSync_q <= {sclSync_q[1:0], scl};
      sdaSync_q <= {sdaSync_q[1:0], sdaIn};
    end
  end

  wire sclHigh   = sclSync_q[1] & sclSync_q[2];
  wire sclRise   = sclSync_q[1] & ~sclSync_q[2];
  wire sclFall   = ~sclSync_q[1] & sclSync_q[2];
  wire sdaLevel  = sdaSync_q[1];
  wire startSeen = sclHigh & sdaSync_q[2] & ~sdaSync_q[1];
  wire stopSeen  = sclHigh & ~sdaSync_q[2] & sdaSync_q[1];
  wire byteDone  = bitCnt_q == `BYTE_BITS;
  wire addrMatch = shift_q[7:1] == DEV_ADDR;

  // A register is read when its byte is loaded for sending
  wire readFire = sclFall & ((state_q == ADDR_ACK & rw_q) | (state_q == HOST_ACK & ackd_q));
  wire ptrWrite = sclFall & (state_q == PTR) & byteDone & firstPtr_q;

  // Sample buffer; holding it back during a high/low pair keeps both bytes coherent
  wire drainValid = count_q != '0;
  // A high byte loaded this cycle must not see its sample replaced under it
  wire highLoad   = readFire & ((ptr_q == `REG_X_HIGH) | (ptr_q == `REG_Y_HIGH) |
                                (ptr_q == `REG_Z_HIGH));
  wire update     = drainValid & ~pairLock_q & ~highLoad;
  wire pushFire   = sampleValid & sampleReady;
  assign sampleReady = count_q != (PW+1)'(BUF_DEPTH);

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      wrIdx_q <= '0;
      rdIdx_q <= '0;
      count_q <= '0;
    end else begin
      if (pushFire) begin
        buf_q[wrIdx_q] <= {sampleZ, sampleY, sampleX};
        wrIdx_q        <= bump(wrIdx_q);
      end
      if (update)
        rdIdx_q <= bump(rdIdx_q);
      count_q <= count_q + (PW+1)'(pushFire) - (PW+1)'(update);
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      axis_q[0] <= `SAMPLE_RESET;
      axis_q[1] <= `SAMPLE_RESET;
      axis_q[2] <= `SAMPLE_RESET;
    end else if (update) begin
      axis_q[0] <= buf_q[rdIdx_q][11:0];
      axis_q[1] <= buf_q[rdIdx_q][23:12];
      axis_q[2] <= buf_q[rdIdx_q][35:24];
    end
  end

  // Status flags; a new sample wins over a same-cycle clear
  wire [2:0] highRead = {3{readFire}} &
                        {ptr_q == `REG_Z_HIGH, ptr_q == `REG_Y_HIGH, ptr_q == `REG_X_HIGH};
  wire       allRead  = &(seenHigh_q | highRead);
  wire [2:0] newAxisD = (newAxis_q & ~highRead) | {3{update}};
  wire [2:0] overAxisD = (overAxis_q & ~highRead) | ({3{update}} & newAxis_q);
  wire       allNewD  = update | (allNew_q & ~allRead);
  wire       allOverD = (update & allNew_q) | (allOver_q & ~allRead);
  wire [2:0] seenHighD = (update | allRead) ? 3'h0 : (seenHigh_q | highRead);
  wire       modeRead = readFire & (ptr_q == `REG_MODE_VIEW);

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      {allOver_q, overAxis_q, allNew_q, newAxis_q} <= `FLAGS_RESET;
      seenHigh_q         <= 3'h0;
      sleepWakeEventFlag <= 1'b0;
      mode_q             <= `MODE_RESET;
    end else begin
      newAxis_q          <= newAxisD;
      overAxis_q         <= overAxisD;
      allNew_q           <= allNewD;
      allOver_q          <= allOverD;
      seenHigh_q         <= seenHighD;
      sleepWakeEventFlag <= sleepWakeEvent | (sleepWakeEventFlag & ~modeRead);
      mode_q             <= operatingMode;
    end
  end

  // Read data selection
  wire [7:0] statusByte = {allOver_q, overAxis_q, allNew_q, newAxis_q};
  wire [7:0] modeByte   = {6'h00, mode_q};
  logic [7:0] readData;

  always_comb begin
    unique case (ptr_q)
      `REG_SAMPLE_FLAGS: readData = statusByte;
      `REG_X_HIGH:       readData = highByte(axis_q[0]);
      `REG_X_LOW:        readData = lowByte(axis_q[0], pairLock_q);
      `REG_Y_HIGH:       readData = highByte(axis_q[1]);
      `REG_Y_LOW:        readData = lowByte(axis_q[1], pairLock_q);
      `REG_Z_HIGH:       readData = highByte(axis_q[2]);
      `REG_Z_LOW:        readData = lowByte(axis_q[2], pairLock_q);
      `REG_MODE_VIEW:    readData = modeByte;
      default:           readData = 8'h00;
    endcase
  end

  // Pointer and high/low pairing
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ptr_q      <= `REG_SAMPLE_FLAGS;
      pairLock_q <= 1'b0;
    end else if (stopSeen) begin
      ptr_q      <= `REG_SAMPLE_FLAGS;
      pairLock_q <= 1'b0;
    end else begin
      if (startSeen)
        pairLock_q <= 1'b0;
      else if (readFire)
        pairLock_q <= |highRead;
      if (ptrWrite)
        ptr_q <= shift_q;
      else if (readFire)
        ptr_q <= nextPtr(ptr_q, fastRead);
    end
  end

  // Open drain: only low is ever driven
  assign sdaOut = 1'b0;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_q    <= IDLE;
      bitCnt_q   <= 4'h0;
      shift_q    <= 8'h00;
      rw_q       <= 1'b0;
      firstPtr_q <= 1'b0;
      ackd_q     <= 1'b0;
      sdaOe      <= 1'b0;
    end else if (stopSeen) begin
      state_q <= IDLE;
      sdaOe   <= 1'b0;
    end else if (startSeen) begin
      state_q  <= ADDR;
      bitCnt_q <= 4'h0;
      sdaOe    <= 1'b0;
    end else if (sclRise) begin
      if (state_q == ADDR || state_q == PTR) begin
        shift_q  <= {shift_q[6:0], sdaLevel};
        bitCnt_q <= bitCnt_q + 4'h1;
      end
      if (state_q == HOST_ACK)
        ackd_q <= ~sdaLevel;
    end else if (sclFall) begin
      unique case (state_q)
        ADDR: begin
          if (byteDone && addrMatch) begin
            state_q <= ADDR_ACK;
            sdaOe   <= 1'b1;
            rw_q    <= shift_q[0];
          end else if (byteDone) begin
            state_q <= WAIT;
          end
        end
        ADDR_ACK: begin
          if (rw_q) begin
            state_q  <= SEND;
            shift_q  <= readData;
            sdaOe    <= ~readData[7];
            bitCnt_q <= 4'h1;
          end else begin
            state_q    <= PTR;
            sdaOe      <= 1'b0;
            bitCnt_q   <= 4'h0;
            firstPtr_q <= 1'b1;
          end
        end
        PTR: begin
          if (byteDone) begin
            state_q    <= PTR_ACK;
            sdaOe      <= 1'b1;
            firstPtr_q <= 1'b0;
          end
        end
        PTR_ACK: begin
          state_q  <= PTR;
          sdaOe    <= 1'b0;
          bitCnt_q <= 4'h0;
        end
        SEND: begin
          if (byteDone) begin
            state_q <= HOST_ACK;
            sdaOe   <= 1'b0;
          end else begin
            sdaOe    <= ~shift_q[6];
            shift_q  <= {shift_q[6:0], 1'b0};
            bitCnt_q <= bitCnt_q + 4'h1;
          end
        end
        HOST_ACK: begin
          if (ackd_q) begin
            state_q  <= SEND;
            shift_q  <= readData;
            sdaOe    <= ~readData[7];
            bitCnt_q <= 4'h1;
          end else begin
            state_q <= WAIT;
          end
        end
        IDLE, WAIT: begin
          state_q <= state_q;
        end
      endcase
    end
  end

  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  a_combined_overrun_set: assert property (update && allNew_q |=> allOver_q)
    else $error("combined overrun not set on overwrite");
  a_combined_overrun_hold: assert property (allOver_q && !allRead |=> allOver_q)
    else $error("combined overrun cleared early");
  a_axis_overrun_set: assert property (update && newAxis_q[1] |=> overAxis_q[1])
    else $error("axis overrun not set");
  a_axis_overrun_clear: assert property (highRead[2] && !update |=> !overAxis_q[2])
    else $error("axis overrun not cleared by high read");
  a_combined_new_set: assert property (update |=> allNew_q && (&newAxis_q))
    else $error("new-sample flags not set");
  a_combined_new_hold: assert property (allNew_q && !allRead |=> allNew_q)
    else $error("combined new-sample cleared early");
  a_axis_new_clear: assert property (highRead[0] && !update |=> !newAxis_q[0])
    else $error("axis new-sample not cleared");
  a_pair_coherent: assert property (
      pairLock_q || (readFire && ptr_q == `REG_Y_HIGH) |=> $stable(axis_q[1]))
    else $error("sample changed between high and low read");
  a_pair_bounded: assert property (pairLock_q |-> ##[0:40] !pairLock_q || sclHigh)
    else $error("pair lock stuck with bus idle");
  a_fast_skip: assert property (
      readFire && fastRead && ptr_q == `REG_X_HIGH |=> ptr_q == `REG_Y_HIGH)
    else $error("fast read did not skip low byte");
  a_full_wrap: assert property (
      readFire && !fastRead && ptr_q == `REG_LAST_FULL |=> ptr_q == `REG_SAMPLE_FLAGS)
    else $error("burst did not wrap after last sample byte");
  a_stop_clears: assert property (stopSeen |=> ptr_q == `REG_SAMPLE_FLAGS && !sdaOe)
    else $error("stop did not clear pointer");
  a_mode_read_clear: assert property (modeRead && !sleepWakeEvent |=> !sleepWakeEventFlag)
    else $error("mode read did not clear sleep/wake flag");
  a_low_gated: assert property (!pairLock_q && ptr_q == `REG_X_LOW |-> readData == 8'h00)
    else $error("low byte readable without preceding high");

endmodule : accel_sample_readout_regs
`default_nettype wire

// ### i2c_host_model.sv
// Behavioural I2C host that reads the sample registers
`timescale 1ns/100ps
`default_nettype none
module i2c_host_model #(
  parameter logic [6:0] DEV_ADDR = 7'h1C // Arbitrary bus address
) (
  input  wire logic clk,
  input  wire logic sdaOe,
  output logic      scl,
  output logic      sdaWire
);
  logic hostPull = 1'b0;
  logic holdBus  = 1'b0;
  logic stalled  = 1'b0;
  int   nNack    = 0;
  // Open drain with pull-up: a released line reads high
  assign sdaWire = ~(hostPull | sdaOe);
  initial scl = 1'b1;
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  // Five clocks low, three high: keeps the device's minimum low time
  task automatic bitX(input logic b, output logic s);
    tick(1);
    hostPull = ~b;
    tick(4);
    scl = 1'b1;
    tick(3);
    s = sdaWire;
    scl = 1'b0;
  endtask : bitX
  // Start (or repeated start) when stop is 0, stop condition otherwise
  task automatic cond(input logic stop);
    tick(1);
    hostPull = stop;
    tick(4);
    scl = 1'b1;
    tick(4);
    hostPull = ~stop;
    tick(4);
    scl = stop;
  endtask : cond
  task automatic sendByte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bitX(d[i], s);
    bitX(1'b1, s);
    ack = ~s;
  endtask : sendByte
  task automatic getByte(input logic more, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bitX(1'b1, s);
      d[i] = s;
    end
    bitX(~more, s);
  endtask : getByte
  // Negative ptr skips the pointer write
  task automatic readRegs(input int ptr, input int n, output logic [7:0] q[$]);
    logic       a;
    logic [7:0] d;
    q = {};
    cond(1'b0);
    if (ptr >= 0) begin
      sendByte({DEV_ADDR, 1'b0}, a);
      nNack += int'(!a);
      sendByte(8'(ptr), a);
      nNack += int'(!a);
      cond(1'b0);
    end
    sendByte({DEV_ADDR, 1'b1}, a);
    nNack += int'(!a);
    // Clock stretch with the first byte loaded but not yet shifted out
    stalled = holdBus;
    while (holdBus) tick(1);
    stalled = 1'b0;
    for (int i = 0; i < n; i++) begin
      getByte(i < n - 1, d);
      q.push_back(d);
    end
    cond(1'b1);
  endtask : readRegs
endmodule : i2c_host_model
`default_nettype wire

// ### tb.sv
// Self-checking bench for the sample read-out registers
`timescale 1ns/100ps
`default_nettype none
module tb import accel_sample_readout_pkg::*;
;
  localparam logic [6:0] DEV = 7'h1C; // Arbitrary bus address
  logic       clk = 1'b0, reset_n = 1'b0, scl, sdaWire, sdaOe, sampleReady;
  logic       sampleValid = 1'b0, fastRead = 1'b0, sleepWakeEvent = 1'b0;
  logic       sleepWakeEventFlag;
  logic [1:0] operatingMode = 2'h0;
  sample_type sampleX = '0, sampleY = '0, sampleZ = '0;
  logic [31:0] lfsr = 32'h6D11;
  int         n_mismatch = 0, n_compared = 0, cycles = 0;
  int         smp[3], newF[3], ovF[3], hiRd[3], allNew = 0, allOv = 0;
  int         exq[$], pend[$];
  logic [7:0] got[$];
  always #12.5 clk = ~clk;
  accel_sample_readout_regs #(.DEV_ADDR(DEV)) i_accel_sample_readout_regs (
    .clk(clk), .reset_n(reset_n), .scl(scl), .sdaIn(sdaWire), .sdaOut(), .sdaOe(sdaOe),
    .sampleValid(sampleValid), .sampleReady(sampleReady), .sampleX(sampleX),
    .sampleY(sampleY), .sampleZ(sampleZ), .fastRead(fastRead), .operatingMode(operatingMode),
    .sleepWakeEvent(sleepWakeEvent), .sleepWakeEventFlag(sleepWakeEventFlag));
  i2c_host_model #(.DEV_ADDR(DEV)) i_i2c_host_model (
    .clk(clk), .sdaOe(sdaOe), .scl(scl), .sdaWire(sdaWire));
  task automatic report_and_stop();
    if (n_mismatch == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop
  // Whole run needs about 7500 clocks
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      n_mismatch++;
      report_and_stop();
    end
  end
  task automatic cmpByte(input logic [7:0] g, input logic [7:0] e);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : cmpByte
  task automatic cmpBit(input logic g, input logic e);
    cmpByte({7'h00, g}, {7'h00, e});
  endtask : cmpBit
  function automatic logic [31:0] nextRand(input logic [31:0] v);
    return {v[30:0], ^(v & 32'h80200003)};
  endfunction : nextRand
  task automatic refMove(input int x, input int y, input int z);
    smp = '{x, y, z};
    allOv |= allNew;
    allNew = 1;
    for (int a = 0; a < 3; a++) begin
      ovF[a] |= newF[a];
      newF[a] = 1;
      hiRd[a] = 0;
    end
  endtask : refMove
  task automatic drain();
    while (pend.size() >= 3) begin
      refMove(pend[0], pend[1], pend[2]);
      repeat (3) void'(pend.pop_front());
    end
  endtask : drain
  task automatic refBurst(input int ptr, input int n);
    int p, prev, a;
    p = ptr;
    prev = -1;
    exq = {};
    for (int i = 0; i < n; i++) begin
      a = (p - 1) / 2;
      if (p == 0) exq.push_back(allOv * 128 + ovF[2] * 64 + ovF[1] * 32 + ovF[0] * 16
                                + allNew * 8 + newF[2] * 4 + newF[1] * 2 + newF[0]);
      else if (p <= 6 && p % 2 == 1) begin
        exq.push_back(smp[a] >> 4);
        newF[a] = 0;
        ovF[a] = 0;
        hiRd[a] = 1;
        if (hiRd[0] && hiRd[1] && hiRd[2]) begin
          allNew = 0;
          allOv = 0;
        end
      end else if (p <= 6 && prev == p - 1) exq.push_back((smp[a] & 15) * 16);
      else if (p == 11) exq.push_back(int'(operatingMode));
      else exq.push_back(0);
      prev = p;
      p = (p == 6 || (fastRead && p == 5)) ? 0 : (fastRead && p < 6 && p % 2 == 1) ? p + 2 : p + 1;
    end
  endtask : refBurst
  // A stop leaves the pointer at status, so a negative ptr reads from 0
  task automatic doRead(input int ptr, input int n);
    i_i2c_host_model.readRegs(ptr, n, got);
    refBurst(ptr < 0 ? 0 : ptr, n);
    cmpByte(8'(got.size()), 8'(n));
    for (int i = 0; i < n; i++) cmpByte(got[i], 8'(exq[i]));
  endtask : doRead
  task automatic push();
    int   k;
    logic ok;
    @(posedge clk);
    #1;
    lfsr = nextRand(lfsr);
    sampleX = lfsr[11:0];
    sampleY = lfsr[23:12];
    sampleZ = {lfsr[31:24], lfsr[3:0]};
    sampleValid = 1'b1;
    k = 0;
    do begin
      ok = sampleReady;
      @(posedge clk);
      #1;
      k++;
    end while (!ok && k < 500);
    sampleValid = 1'b0;
    pend.push_back(int'(sampleX));
    pend.push_back(int'(sampleY));
    pend.push_back(int'(sampleZ));
  endtask : push
  initial begin
    logic ack;
    repeat (10) @(posedge clk);
    #1;
    reset_n = 1'b1;
    repeat (6) @(posedge clk);
    #1;
    doRead(0, 7);
    doRead(11, 1);
    push();
    drain();
    doRead(0, 7);
    push();
    push();
    drain();
    for (int i = 0; i < 6; i++) doRead(i % 2 ? 1 + 2 * (i / 2) : 0, 1);
    i_i2c_host_model.holdBus = 1'b1;
    fork
      doRead(1, 2);
      begin
        wait (i_i2c_host_model.stalled);
        push();
        push();
        cmpBit(sampleReady, 1'b0);
        i_i2c_host_model.holdBus = 1'b0;
      end
    join
    drain();
    push();
    drain();
    doRead(0, 1);
    fastRead = 1'b1;
    doRead(0, 5);
    fastRead = 1'b0;
    doRead(2, 1);
    doRead(8, 1);
    doRead(3, 1);
    doRead(-1, 2);
    for (int m = 0; m < 3; m++) begin
      operatingMode = 2'(m);
      sleepWakeEvent = 1'b1;
      @(posedge clk);
      #1;
      sleepWakeEvent = 1'b0;
      @(posedge clk);
      #1;
      cmpBit(sleepWakeEventFlag, 1'b1);
      doRead(11, 1);
      cmpBit(sleepWakeEventFlag, 1'b0);
    end
    i_i2c_host_model.cond(1'b0);
    i_i2c_host_model.sendByte({DEV ^ 7'h01, 1'b1}, ack);
    i_i2c_host_model.cond(1'b1);
    cmpBit(ack, 1'b0);
    cmpByte(8'(i_i2c_host_model.nNack), 8'h00);
    report_and_stop();
  end
endmodule : tb
`default_nettype wire
